// [hw/sdf_params.svh]
// Purpose: constants of the sd status flag block
// Assumes: included by bare name
// Notes: offsets are byte addresses on the register bus
`ifndef SDF_PARAMS_SVH
`define SDF_PARAMS_SVH

// register offsets
`define SDF_OFS_STATUS     4'h0
`define SDF_OFS_ENABLE     4'h4

// status and enable bit positions
`define SDF_BIT_CARD_IRQ   10
`define SDF_BIT_CARD_DET   8
`define SDF_BIT_DAT0       7
`define SDF_TOK_HI         6
`define SDF_TOK_LO         4
`define SDF_BIT_CRC16_OK   3
`define SDF_BIT_CRC7_OK    2
`define SDF_BIT_CRC_ERR    1

// reset values
`define SDF_RST_ENABLE     32'h0000_0000
`define SDF_RST_TOKEN      3'h0
`define SDF_RST_CRC_OK     1'b1

// token codes
`define SDF_TOK_POSITIVE   3'h2
`define SDF_TOK_NEGATIVE   3'h5
`define SDF_TOK_PROG_ERR   3'h7

// crc generators, top bit implied
`define SDF_CRC7_POLY      7'h09
`define SDF_CRC16_POLY     16'h1021

// bus answers
`define SDF_RESP_OKAY      2'h0
`define SDF_RESP_SLVERR    2'h2

`endif

// [hw/sdf_pkg.sv]
// Purpose: types of the sd status flag block
// Assumes: nothing
// Notes: constants live in sdf_params.svh
package sdf_pkg;

   // read channel states, one-hot
   typedef enum logic [1:0] {
      SDF_RD_IDLE = 2'b01,
      SDF_RD_RESP = 2'b10
   } sdf_rd_state_t;

endpackage : sdf_pkg

// [hw/sdf_sync.sv]
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs come from outside the aclk domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sdf_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   ///////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         // pins other than the link clock idle high, so reset to one avoids a false edge
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta <= 1'b1;
               q[i] <= 1'b1;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate

endmodule : sdf_sync

// [hw/sdf_crc.sv]
// Purpose: serial crc register for link frames
// Assumes: one bit per enable, msb first
// Notes: feeding the crc bits too leaves zero when the frame is good
`timescale 1ns/1ps
module sdf_crc #(
   parameter int         W    = 7,
   parameter logic [W-1:0] POLY = '0
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // bit stream
   input  wire logic         clear,
   input  wire logic         shift,
   input  wire logic         din,
   // remainder
   output logic      [W-1:0] crc
);

   ///////////////////////////////////////////////////////////////////////////
   logic fb;
   assign fb = din ^ crc[W-1];

   // clear has priority so a new frame never inherits old bits
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         crc <= '0;
      end else if (shift) begin
         crc <= {crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
      end
   end

endmodule : sdf_crc

// [hw/sdf_status.sv]
// Purpose: status and interrupt flags of an sd host, axi4-lite slave
// Assumes: framing strobes come from the card engine on aclk
// Notes: link pins are sampled by aclk through two flops
// Operation
// - card insert or removal sets detect flag, only while its enable is one
// - sdio card interrupt sets card interrupt flag
// - flags are cleared by writing one, writing zero keeps them
// - status shows live level of data line zero
// - three-bit write crc token captured after each data-out block
// - data-in crc-16 result shown, one good, zero bad
// - response crc-7 result shown, one good, zero bad
// - any crc-7, crc-16 or token error sets combined crc error flag
// - crc-7 checked even without crc field, so error flag sets too
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sdf_params.svh"
module sdf_status (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [3:0]  awaddr,
   input  wire logic [2:0]  awprot,
   // axi4-lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // axi4-lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // axi4-lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [3:0]  araddr,
   input  wire logic [2:0]  arprot,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // link pins, observed only
   input  wire logic        sd_clk_pin,
   input  wire logic        sd_cmd_pin,
   input  wire logic        sd_dat0_pin,
   input  wire logic        sd_dat1_pin,
   input  wire logic        card_present_pin,
   // framing from the card engine
   input  wire logic        rsp_active,
   input  wire logic        din_active,
   input  wire logic        tok_active,
   input  wire logic        irq_window,
   // interrupt
   output logic             irq
);

   ///////////////////////////////////////////////////////////////////////////
   // pin sampling
   logic [4:0] pins_s;
   logic       clk_s;
   logic       cmd_s;
   logic       dat0_s;
   logic       dat1_s;
   logic       present_s;
   logic       clk_d;
   logic       present_d;
   logic       link_rise;

   sdf_sync #(.W(5)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({sd_clk_pin, sd_cmd_pin, sd_dat0_pin, sd_dat1_pin, card_present_pin}),
      .q       (pins_s)
   );
   assign {clk_s, cmd_s, dat0_s, dat1_s, present_s} = pins_s;

   // edge finders look at the synchronised levels only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_d     <= 1'b1;
         present_d <= 1'b1;
      end else begin
         clk_d     <= clk_s;
         present_d <= present_s;
      end
   end
   assign link_rise = clk_s & ~clk_d;

   ///////////////////////////////////////////////////////////////////////////
   // frame tracking
   logic rsp_d;
   logic din_d;
   logic tok_d;
   logic rsp_end;
   logic din_end;
   logic tok_end;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp_d <= 1'b0;
         din_d <= 1'b0;
         tok_d <= 1'b0;
      end else begin
         rsp_d <= rsp_active;
         din_d <= din_active;
         tok_d <= tok_active;
      end
   end
   assign rsp_end = rsp_d & ~rsp_active;
   assign din_end = din_d & ~din_active;
   assign tok_end = tok_d & ~tok_active;

   ///////////////////////////////////////////////////////////////////////////
   // crc engines and token shifter
   logic [6:0]  crc7;
   logic [15:0] crc16;
   logic [2:0]  tok_shift;

   sdf_crc #(.W(7), .POLY(`SDF_CRC7_POLY)) u_crc7 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (rsp_active & ~rsp_d),
      .shift   (rsp_active & link_rise),
      .din     (cmd_s),
      .crc     (crc7)
   );

   sdf_crc #(.W(16), .POLY(`SDF_CRC16_POLY)) u_crc16 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (din_active & ~din_d),
      .shift   (din_active & link_rise),
      .din     (dat0_s),
      .crc     (crc16)
   );

   // token bits arrive msb first on data line zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tok_shift <= `SDF_RST_TOKEN;
      end else if (tok_active & link_rise) begin
         tok_shift <= {tok_shift[1:0], dat0_s};
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // check results
   logic       crc7_ok;
   logic       crc16_ok;
   logic [2:0] write_crc_token;
   logic       crc7_bad;
   logic       crc16_bad;
   logic       tok_bad;

   assign crc7_bad  = rsp_end & (crc7 != 7'h00);
   assign crc16_bad = din_end & (crc16 != 16'h0000);
   assign tok_bad   = tok_end & (tok_shift != `SDF_TOK_POSITIVE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc7_ok <= `SDF_RST_CRC_OK;
      end else if (rsp_end) begin
         crc7_ok <= ~crc7_bad;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc16_ok <= `SDF_RST_CRC_OK;
      end else if (din_end) begin
         crc16_ok <= ~crc16_bad;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_crc_token <= `SDF_RST_TOKEN;
      end else if (tok_end) begin
         write_crc_token <= tok_shift;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   logic        aw_got;
   logic        w_got;
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic [31:0] wr_mask;
   logic        wr_en;
   logic        wr_status;
   logic        wr_enable;

   assign wr_en     = aw_got & w_got & ~bvalid;
   assign wr_status = wr_en & (wr_addr == `SDF_OFS_STATUS);
   assign wr_enable = wr_en & (wr_addr == `SDF_OFS_ENABLE);

   // address and data are taken in either order and held until the answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got  <= 1'b0;
         awready <= 1'b1;
         wr_addr <= 4'h0;
      end else if (awvalid & awready) begin
         aw_got  <= 1'b1;
         awready <= 1'b0;
         wr_addr <= {awaddr[3:2], 2'b00};
      end else if (bvalid & bready) begin
         aw_got  <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got   <= 1'b0;
         wready  <= 1'b1;
         wr_data <= 32'h0000_0000;
         wr_mask <= 32'h0000_0000;
      end else if (wvalid & wready) begin
         w_got   <= 1'b1;
         wready  <= 1'b0;
         wr_data <= wdata;
         wr_mask <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      end else if (bvalid & bready) begin
         w_got   <= 1'b0;
         wready  <= 1'b1;
      end
   end

   // response one cycle after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `SDF_RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp  <= (wr_status | wr_enable) ? `SDF_RESP_OKAY : `SDF_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // enable register, same layout as the status flags
   logic [31:0] enable_reg;
   logic [31:0] clr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= `SDF_RST_ENABLE;
      end else if (wr_enable) begin
         enable_reg <= (enable_reg & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   assign clr = wr_status ? (wr_data & wr_mask) : 32'h0000_0000;

   ///////////////////////////////////////////////////////////////////////////
   // sticky flags, a set in the clearing cycle wins
   logic card_irq_flag;
   logic card_detect_flag;
   logic crc_error_flag;
   logic card_detect_irq_enable;
   logic card_irq_enable;
   logic crc_error_irq_enable;
   logic cd_edge;
   logic cirq_seen;
   logic crc_set;

   assign card_detect_irq_enable = enable_reg[`SDF_BIT_CARD_DET];
   assign card_irq_enable        = enable_reg[`SDF_BIT_CARD_IRQ];
   assign crc_error_irq_enable   = enable_reg[`SDF_BIT_CRC_ERR];
   assign cd_edge   = present_s ^ present_d;
   // the card pulls line one low inside the interrupt window
   assign cirq_seen = irq_window & ~dat1_s;
   assign crc_set   = crc7_bad | crc16_bad | tok_bad;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         card_detect_flag <= 1'b0;
      end else if (cd_edge & card_detect_irq_enable) begin
         card_detect_flag <= 1'b1;
      end else if (clr[`SDF_BIT_CARD_DET]) begin
         card_detect_flag <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         card_irq_flag <= 1'b0;
      end else if (cirq_seen) begin
         card_irq_flag <= 1'b1;
      end else if (clr[`SDF_BIT_CARD_IRQ]) begin
         card_irq_flag <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_error_flag <= 1'b0;
      end else if (crc_set) begin
         crc_error_flag <= 1'b1;
      end else if (clr[`SDF_BIT_CRC_ERR]) begin
         crc_error_flag <= 1'b0;
      end
   end

   logic data0_line_level;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data0_line_level <= 1'b1;
      end else begin
         data0_line_level <= dat0_s;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // interrupt from enabled flags
   logic irq_any;
   assign irq_any = (card_irq_flag & card_irq_enable)
                  | (card_detect_flag & card_detect_irq_enable)
                  | (crc_error_flag & crc_error_irq_enable);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_any;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   sdf_pkg::sdf_rd_state_t rd_state;
   logic [31:0]            status_word;

   always_comb begin
      status_word                          = 32'h0000_0000;
      status_word[`SDF_BIT_CARD_IRQ]       = card_irq_flag;
      status_word[`SDF_BIT_CARD_DET]       = card_detect_flag;
      status_word[`SDF_BIT_DAT0]           = data0_line_level;
      status_word[`SDF_TOK_HI:`SDF_TOK_LO] = write_crc_token;
      status_word[`SDF_BIT_CRC16_OK]       = crc16_ok;
      status_word[`SDF_BIT_CRC7_OK]        = crc7_ok;
      status_word[`SDF_BIT_CRC_ERR]        = crc_error_flag;
   end

   // data are frozen at the address handshake, so rdata holds while waiting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= sdf_pkg::SDF_RD_IDLE;
         arready  <= 1'b1;
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= `SDF_RESP_OKAY;
      end else begin
         case (rd_state)
            sdf_pkg::SDF_RD_IDLE: begin
               if (arvalid) begin
                  rd_state <= sdf_pkg::SDF_RD_RESP;
                  arready  <= 1'b0;
                  rvalid   <= 1'b1;
                  case ({araddr[3:2], 2'b00})
                     `SDF_OFS_STATUS: begin
                        rdata <= status_word;
                        rresp <= `SDF_RESP_OKAY;
                     end
                     `SDF_OFS_ENABLE: begin
                        rdata <= enable_reg;
                        rresp <= `SDF_RESP_OKAY;
                     end
                     default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= `SDF_RESP_SLVERR;
                     end
                  endcase
               end
            end
            sdf_pkg::SDF_RD_RESP: begin
               if (rready) begin
                  rd_state <= sdf_pkg::SDF_RD_IDLE;
                  arready  <= 1'b1;
                  rvalid   <= 1'b0;
               end
            end
            default: begin
               rd_state <= sdf_pkg::SDF_RD_IDLE;
               arready  <= 1'b1;
               rvalid   <= 1'b0;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_cd_event;
      cd_edge && card_detect_irq_enable;
   endsequence
   property p_cd_set;
      s_cd_event |=> card_detect_flag ##1 (card_detect_flag || $past(clr[`SDF_BIT_CARD_DET]));
   endproperty
   a_cd_set: assert property (p_cd_set) else $error("detect flag not set");

   property p_cd_gate;
      (!card_detect_flag && !(cd_edge && card_detect_irq_enable)) |=> !card_detect_flag;
   endproperty
   a_cd_gate: assert property (p_cd_gate) else $error("detect flag set while gated");

   property p_cirq_set;
      cirq_seen |=> card_irq_flag;
   endproperty
   a_cirq_set: assert property (p_cirq_set) else $error("card irq flag missed");

   property p_clear;
      (clr[`SDF_BIT_CRC_ERR] && !crc_set) |=> !crc_error_flag ##1 ($past(crc_set) || !crc_error_flag);
   endproperty
   a_clear: assert property (p_clear) else $error("crc flag not cleared");

   property p_dat0;
      ##3 data0_line_level == $past(sd_dat0_pin, 3);
   endproperty
   a_dat0: assert property (p_dat0) else $error("data line level stale");

   property p_token;
      tok_end |=> write_crc_token == $past(tok_shift)
         && crc_error_flag == (write_crc_token != `SDF_TOK_POSITIVE
         || $past(crc_error_flag && !clr[`SDF_BIT_CRC_ERR]) || $past(crc7_bad | crc16_bad));
   endproperty
   a_token: assert property (p_token) else $error("token capture wrong");

   property p_crc16;
      din_end |=> crc16_ok == ($past(crc16) == 16'h0000);
   endproperty
   a_crc16: assert property (p_crc16) else $error("crc-16 result wrong");

   sequence s_rsp_bad;
      rsp_end && crc7 != 7'h00;
   endsequence
   property p_crc7;
      s_rsp_bad |=> !crc7_ok && crc_error_flag;
   endproperty
   a_crc7: assert property (p_crc7) else $error("crc-7 error not flagged");

   property p_irq;
      irq_any |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : sdf_status

// [verif/sdf_card_model.sv]
// Purpose: behavioural sd card and engine framing for the status block
// Assumes: every pin changes just after an aclk edge
// Notes: link clock idles low between frames; released lines float high
`timescale 1ns/1ps
module sdf_card_model (
   // clock
   input  wire logic aclk,
   // link pins
   output logic      sd_clk_pin,
   output logic      sd_cmd_pin,
   output logic      sd_dat0_pin,
   output logic      sd_dat1_pin,
   output logic      card_present_pin,
   // engine framing
   output logic      rsp_active,
   output logic      din_active,
   output logic      tok_active,
   output logic      irq_window
);
   // idle levels, pull-ups hold the lines high
   initial begin
      {sd_clk_pin, rsp_active, din_active, tok_active, irq_window} = 5'h00;
      {sd_cmd_pin, sd_dat0_pin, sd_dat1_pin, card_present_pin} = 4'hF;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one frame msb first at 200 ns per bit; kind 0 response, 1 data-in, 2 token
   task automatic frame(input int kind, input logic [63:0] bits, input int n);
      int i;
      @(posedge aclk);
      rsp_active <= (kind == 0);
      din_active <= (kind == 1);
      tok_active <= (kind == 2);
      for (i = n - 1; i >= 0; i--) begin
         if (kind == 0) sd_cmd_pin <= bits[i];
         else sd_dat0_pin <= bits[i];
         repeat (4) @(posedge aclk);
         sd_clk_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         sd_clk_pin <= 1'b0;
      end
      // the last rise needs time to pass the synchroniser
      repeat (4) @(posedge aclk);
      {rsp_active, din_active, tok_active} <= 3'h0;
      sd_cmd_pin <= 1'b1;
      sd_dat0_pin <= 1'b1;
   endtask : frame
   // card pulls data line one low inside the interrupt period
   task automatic card_irq();
      @(posedge aclk);
      irq_window <= 1'b1;
      sd_dat1_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      sd_dat1_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      irq_window <= 1'b0;
   endtask : card_irq
   task automatic toggle_present();
      @(posedge aclk);
      card_present_pin <= ~card_present_pin;
   endtask : toggle_present
   task automatic set_dat0(input logic v);
      @(posedge aclk);
      sd_dat0_pin <= v;
   endtask : set_dat0
endmodule : sdf_card_model

// [verif/sd_host_status_flags_tb.sv]
// Purpose: self-checking bench of the sd status flag block
// Assumes: axi4-lite master, card model on the link pins
// Notes: expected crc values are built here from the generators
`timescale 1ns/1ps
`include "sdf_params.svh"
module sd_host_status_flags_tb;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        clk_p, cmd_p, dat0_p, dat1_p, pres_p, rsp_a, din_a, tok_a, irq_w;
   int          fails, samples_checked;
   sdf_status dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .sd_clk_pin(clk_p), .sd_cmd_pin(cmd_p),
      .sd_dat0_pin(dat0_p), .sd_dat1_pin(dat1_p), .card_present_pin(pres_p),
      .rsp_active(rsp_a), .din_active(din_a), .tok_active(tok_a), .irq_window(irq_w),
      .irq(irq));
   sdf_card_model card (.aclk(aclk), .sd_clk_pin(clk_p), .sd_cmd_pin(cmd_p),
      .sd_dat0_pin(dat0_p), .sd_dat1_pin(dat1_p), .card_present_pin(pres_p),
      .rsp_active(rsp_a), .din_active(din_a), .tok_active(tok_a), .irq_window(irq_w));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // write and read hold every channel until its own handshake edge
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                     output logic [1:0] rs);
      rs = 2'h3;
      @(posedge aclk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      // only the watchdog ends a wait for the answer
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      {v, rs} = 34'h0_0000_0003;
      @(posedge aclk);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   task automatic st(output logic [31:0] v);
      logic [1:0] rs;
      rd(`SDF_OFS_STATUS, v, rs);
   endtask : st
   task automatic clr(input logic [31:0] m);
      logic [1:0] rs;
      wr(`SDF_OFS_STATUS, m, 4'hF, rs);
      repeat (3) @(posedge aclk);
   endtask : clr
   function automatic logic [6:0] crc7(input logic [39:0] m);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? `SDF_CRC7_POLY : 7'h00);
      return c;
   endfunction : crc7
   function automatic logic [15:0] crc16(input logic [15:0] m);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((m[i] ^ c[15]) ? `SDF_CRC16_POLY : 16'h0);
      end
      return c;
   endfunction : crc16
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      st(d);
      chk(d, 32'h0000_008C);
      clr(32'hFFFF_FFFF);
      st(d);
      chk(d, 32'h0000_008C);
      rd(4'hC, d, r);
      chk({d[31:2], r}, {30'h0, `SDF_RESP_SLVERR});
      wr(4'h8, 32'h1, 4'hF, r);
      chk({30'h0, r}, {30'h0, `SDF_RESP_SLVERR});
      wr(`SDF_OFS_ENABLE, 32'hA5A5_5A5A, 4'hF, r);
      wr(`SDF_OFS_ENABLE, 32'hFFFF_FFFF, 4'h1, r);
      rd(`SDF_OFS_ENABLE, d, r);
      chk(d, 32'hA5A5_5AFF);
      wr(`SDF_OFS_ENABLE, 32'h0, 4'hF, r);
   endtask : t_regs
   // detect flag only follows a change while its enable is set
   task automatic t_detect();
      card.toggle_present();
      repeat (10) @(posedge aclk);
      st(d);
      chk(d & 32'h100, 32'h0);
      wr(`SDF_OFS_ENABLE, 32'h0000_0502, 4'hF, r);
      card.toggle_present();
      repeat (10) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      clr(32'h0);
      st(d);
      chk(d & 32'h100, 32'h100);
      clr(32'h100);
      chk({31'h0, irq}, 32'h0);
      st(d);
      chk(d & 32'h100, 32'h0);
   endtask : t_detect
   task automatic t_card_irq();
      card.card_irq();
      repeat (4) @(posedge aclk);
      st(d);
      chk(d & 32'h400, 32'h400);
      clr(32'h400);
      st(d);
      chk(d & 32'h400, 32'h0);
   endtask : t_card_irq
   task automatic t_dat0();
      card.set_dat0(1'b0);
      repeat (6) @(posedge aclk);
      st(d);
      chk(d & 32'h80, 32'h0);
      card.set_dat0(1'b1);
      repeat (6) @(posedge aclk);
      st(d);
      chk(d & 32'h80, 32'h80);
   endtask : t_dat0
   // every token code; only the positive one leaves the error flag clear
   task automatic t_token();
      logic [2:0] codes [3];
      codes = '{`SDF_TOK_POSITIVE, `SDF_TOK_NEGATIVE, `SDF_TOK_PROG_ERR};
      foreach (codes[i]) begin
         card.frame(2, 64'(codes[i]), 3);
         repeat (4) @(posedge aclk);
         st(d);
         chk(d & 32'h70, 32'(codes[i]) << 4);
         chk(d & 32'h2, (codes[i] == 3'h2) ? 32'h0 : 32'h2);
         clr(32'h2);
      end
   endtask : t_token
   task automatic t_crc16();
      for (int g = 1; g >= 0; g--) begin
         card.frame(1, 64'({16'hC3A5, crc16(16'hC3A5) ^ 16'(1 - g)}), 32);
         repeat (4) @(posedge aclk);
         st(d);
         chk(d & 32'hA, (g == 1) ? 32'h8 : 32'h2);
         clr(32'h2);
      end
   endtask : t_crc16
   // a good response passes; one with a corrupted crc field is checked and flagged
   task automatic t_crc7();
      card.frame(0, 64'({40'h11_2233_4455, crc7(40'h11_2233_4455)}), 47);
      repeat (4) @(posedge aclk);
      st(d);
      chk(d & 32'h6, 32'h4);
      card.frame(0, 64'({40'h3F_0000_FF00, crc7(40'h3F_0000_FF00) ^ 7'h01}), 47);
      repeat (4) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      // software drops the crc interrupt for such responses
      wr(`SDF_OFS_ENABLE, 32'h0000_0500, 4'hF, r);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      st(d);
      chk(d & 32'h6, 32'h2);
      clr(32'h2);
      st(d);
      chk(d & 32'h6, 32'h0);
   endtask : t_crc7
   task automatic results();
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wstrb, wdata} = 44'h0;
      fails = 0;
      samples_checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      t_regs();
      t_detect();
      t_card_irq();
      t_dat0();
      t_token();
      t_crc16();
      t_crc7();
      results();
   end
   // watchdog well beyond the under two thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      results();
   end
endmodule : sd_host_status_flags_tb
